// ### ifb_bank.sv
// Chosen here: the APB register port and the register addresses.
`include "ifb_regs.svh"

module ifb_bank #(
  parameter int NUM_SLOTS = 48
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [15:0] i_evt_flags_0,
  input wire logic [15:0] i_evt_flags_1,
  input wire logic [15:0] i_evt_flags_2,
  input wire logic [15:0] i_en_ext_1,
  input wire logic [15:0] i_en_ext_2,
  input wire ifb_pkg::prio_vec_t i_src_prio,
  output logic [47:0] o_req,
  output logic [2:0] o_req_level,
  output logic o_req_any
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // One-hot word from a bit position
  function automatic ifb_pkg::word16_t bit_at(input logic [3:0] pos);
    ifb_pkg::word16_t w;
    w = `IFB_RST_WORD;
    w[pos] = 1'b1;
    return w;
  endfunction

  // Highest priority among active slots; 0 when none
  function automatic ifb_pkg::prio_t top_prio(input logic [47:0] act,
                                               input ifb_pkg::prio_vec_t pr);
    ifb_pkg::prio_t best;
    best = `IFB_PRIO_OFF;
    for (int k = 0; k < NUM_SLOTS; k++) begin
      if (act[k] && (pr[k] > best)) begin
        best = pr[k];
      end
    end
    return best;
  endfunction

  // Next flag word: sources set, software writes, set beats clear
  function automatic ifb_pkg::word16_t flag_next(input ifb_pkg::word16_t cur,
                                                  input logic wr,
                                                  input ifb_pkg::word16_t wd,
                                                  input ifb_pkg::word16_t evt,
                                                  input ifb_pkg::word16_t impl);
    ifb_pkg::word16_t base;
    base = wr ? wd : cur;
    return (base | evt) & impl;
  endfunction

  // ****************************************************************
  // Implemented bit maps
  // ****************************************************************

  // Flags 0 layout, mirrored by enables 0
  ifb_pkg::word16_t impl_0_hi;
  ifb_pkg::word16_t impl_0_lo;
  ifb_pkg::word16_t impl_0;
  assign impl_0_hi = bit_at(`IFB_B0_I2C_MASTER)
                   | bit_at(`IFB_B0_I2C_SLAVE)
                   | bit_at(`IFB_B0_NVM)
                   | bit_at(`IFB_B0_ADC)
                   | bit_at(`IFB_B0_UART_TX)
                   | bit_at(`IFB_B0_UART_RX)
                   | bit_at(`IFB_B0_SPI);
  assign impl_0_lo = bit_at(`IFB_B0_TIMER3)
                   | bit_at(`IFB_B0_TIMER2)
                   | bit_at(`IFB_B0_TIMER1)
                   | bit_at(`IFB_B0_CMP_OUT2)
                   | bit_at(`IFB_B0_CMP_OUT1)
                   | bit_at(`IFB_B0_CAPTURE1)
                   | bit_at(`IFB_B0_EXT_PIN0);
  assign impl_0 = impl_0_hi | impl_0_lo;        // Bits 15 and 4 stay empty

  // Flags 1 layout; bit 12 and bits 10 to 7 stay empty
  ifb_pkg::word16_t impl_1;
  assign impl_1 = bit_at(`IFB_B1_COMP3)
                | bit_at(`IFB_B1_COMP2)
                | bit_at(`IFB_B1_COMP1)
                | bit_at(`IFB_B1_PIN_CHANGE)
                | bit_at(`IFB_B1_PULSE4)
                | bit_at(`IFB_B1_PULSE3)
                | bit_at(`IFB_B1_PULSE2)
                | bit_at(`IFB_B1_PULSE1)
                | bit_at(`IFB_B1_SPECIAL)
                | bit_at(`IFB_B1_EXT_PIN2)
                | bit_at(`IFB_B1_EXT_PIN1);

  // Flags 2 layout; bits 15 to 11 and 4 to 1 stay empty
  ifb_pkg::word16_t impl_2;
  assign impl_2 = bit_at(`IFB_B2_PAIR5)
                | bit_at(`IFB_B2_PAIR4)
                | bit_at(`IFB_B2_PAIR3)
                | bit_at(`IFB_B2_PAIR2)
                | bit_at(`IFB_B2_PAIR1)
                | bit_at(`IFB_B2_PAIR0)
                | bit_at(`IFB_B2_COMP4);

  // ****************************************************************
  // APB handshake
  // ****************************************************************

  ifb_pkg::apb_phase_t phase_r;
  ifb_pkg::apb_phase_t phase_nxt;
  logic setup_cyc;
  logic access_done;
  logic wr_done;

  // Setup cycle seen; one registered ack keeps pready a flop output
  assign setup_cyc = i_psel && !i_penable;
  assign access_done = i_psel && i_penable && (phase_r == ifb_pkg::PH_ACK);
  assign wr_done = access_done && i_pwrite;

  // Ack lasts one cycle, so every transfer has exactly one access cycle
  always_comb begin
    phase_nxt = ifb_pkg::PH_IDLE;
    case (phase_r)
      ifb_pkg::PH_IDLE: begin
        phase_nxt = setup_cyc ? ifb_pkg::PH_ACK : ifb_pkg::PH_IDLE;
      end
      ifb_pkg::PH_ACK: begin
        phase_nxt = ifb_pkg::PH_IDLE;
      end
      default: begin
        phase_nxt = ifb_pkg::PH_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************

  logic sel_flags_0;
  logic sel_flags_1;
  logic sel_flags_2;
  logic sel_en_0;
  logic sel_pend_lo;
  logic sel_pend_hi;
  logic sel_level;
  logic addr_hit;
  assign sel_flags_0 = (i_paddr == `IFB_OFF_FLAGS_0);
  assign sel_flags_1 = (i_paddr == `IFB_OFF_FLAGS_1);
  assign sel_flags_2 = (i_paddr == `IFB_OFF_FLAGS_2);
  assign sel_en_0 = (i_paddr == `IFB_OFF_ENABLES_0);
  assign sel_pend_lo = (i_paddr == `IFB_OFF_PENDING_LO);
  assign sel_pend_hi = (i_paddr == `IFB_OFF_PENDING_HI);
  assign sel_level = (i_paddr == `IFB_OFF_LEVEL);
  assign addr_hit = sel_flags_0 | sel_flags_1 | sel_flags_2 | sel_en_0
                  | sel_pend_lo | sel_pend_hi | sel_level;

  // ****************************************************************
  // Flag and enable storage
  // ****************************************************************

  ifb_pkg::word16_t flags_0_r;
  ifb_pkg::word16_t flags_1_r;
  ifb_pkg::word16_t flags_2_r;
  ifb_pkg::word16_t en_0_r;
  ifb_pkg::word16_t flags_0_nxt;
  ifb_pkg::word16_t flags_1_nxt;
  ifb_pkg::word16_t flags_2_nxt;
  ifb_pkg::word16_t en_0_nxt;
  ifb_pkg::word16_t wdata;
  assign wdata = i_pwdata[15:0];

  // A pulse in the write cycle still lands, so no event is lost
  assign flags_0_nxt = flag_next(flags_0_r, wr_done && sel_flags_0, wdata,
                                 i_evt_flags_0, impl_0);
  assign flags_1_nxt = flag_next(flags_1_r, wr_done && sel_flags_1, wdata,
                                 i_evt_flags_1, impl_1);
  assign flags_2_nxt = flag_next(flags_2_r, wr_done && sel_flags_2, wdata,
                                 i_evt_flags_2, impl_2);
  // Enables change only by software, empty bits masked off
  assign en_0_nxt = (wr_done && sel_en_0) ? (wdata & impl_0) : en_0_r;

  // ****************************************************************
  // Request generation
  // ****************************************************************

  logic [47:0] flags_all;
  logic [47:0] en_all;
  logic [47:0] prio_live;
  logic [47:0] req_nxt;
  ifb_pkg::prio_t level_nxt;

  // Outside enables are masked by the same empty-bit maps
  assign flags_all = {flags_2_r, flags_1_r, flags_0_r};
  assign en_all = {i_en_ext_2 & impl_2, i_en_ext_1 & impl_1, en_0_r};

  // Priority 0 takes the source out of arbitration
  always_comb begin
    prio_live = '0;
    for (int k = 0; k < NUM_SLOTS; k++) begin
      prio_live[k] = (i_src_prio[k] != `IFB_PRIO_OFF);
    end
  end

  // Request needs flag, enable and live priority
  assign req_nxt = flags_all & en_all & prio_live;
  // Largest value wins, 7 highest
  assign level_nxt = top_prio(req_nxt, i_src_prio);

  // ****************************************************************
  // Read data mux
  // ****************************************************************

  // Registered at setup so the value is stable through the access cycle
  logic [31:0] rd_word;
  logic [31:0] rd_flags;
  logic [31:0] rd_status;
  assign rd_flags = sel_flags_0 ? {16'h0000, flags_0_r}
                  : sel_flags_1 ? {16'h0000, flags_1_r}
                  : sel_flags_2 ? {16'h0000, flags_2_r}
                  : sel_en_0 ? {16'h0000, en_0_r}
                  : `IFB_ZERO_32;  // Upper half and empty bits read 0
  assign rd_status = sel_pend_lo ? {o_req[31:16], o_req[15:0]}
                   : sel_pend_hi ? {16'h0000, o_req[47:32]}
                   : sel_level ? {29'h0000_0000, o_req_level}
                   : `IFB_ZERO_32;
  assign rd_word = (addr_hit && !i_pwrite) ? (rd_flags | rd_status)
                                          : `IFB_ZERO_32;

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Bus handshake state and answer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      phase_r <= ifb_pkg::PH_IDLE;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= `IFB_ZERO_32;
    end else begin
      phase_r <= phase_nxt;
      o_pready <= (phase_nxt == ifb_pkg::PH_ACK);
      o_pslverr <= setup_cyc && !addr_hit;  // Unmapped address errors
      o_prdata <= setup_cyc ? rd_word : `IFB_ZERO_32;
    end
  end

  // Bank contents, all zero after reset
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      flags_0_r <= `IFB_RST_WORD;
      flags_1_r <= `IFB_RST_WORD;
      flags_2_r <= `IFB_RST_WORD;
      en_0_r <= `IFB_RST_WORD;
    end else begin
      flags_0_r <= flags_0_nxt;
      flags_1_r <= flags_1_nxt;
      flags_2_r <= flags_2_nxt;
      en_0_r <= en_0_nxt;
    end
  end

  // Requests trail the flags by one clock to keep outputs on flops
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_req <= '0;
      o_req_level <= `IFB_RST_LEVEL;
      o_req_any <= 1'b0;
    end else begin
      o_req <= req_nxt;
      o_req_level <= level_nxt;
      o_req_any <= (level_nxt != `IFB_PRIO_OFF);
    end
  end

endmodule // ifb_bank

// ### ifb_bank_asserts.sv
module ifb_bank_asserts (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [15:0] i_evt_flags_1,
  input wire logic [15:0] i_en_ext_1,
  input wire ifb_pkg::prio_vec_t i_src_prio,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [47:0] o_req,
  input wire logic [2:0] o_req_level,
  input wire logic o_req_any
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Port checks, all on the one system clock
  // ****************************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  AST_READY_ONE: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("ready not a single cycle after setup");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("error response without ready");
  AST_DATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data not zero outside access");
  // Slot 16 is flags 1 bit 0, enabled from outside the bank
  AST_SET_REQ: assert property (i_evt_flags_1[0] ##1 (i_en_ext_1[0]
      && i_src_prio[16] != 3'h0) |=> o_req[16])
    else $error("pulse did not raise the request");
  AST_EN_BLOCK: assert property (!i_en_ext_1[0] |=> !o_req[16])
    else $error("request passed a cleared enable");
  AST_PRIO_OFF: assert property (i_src_prio[16] == 3'h0 |=> !o_req[16])
    else $error("request from a source at priority zero");
  AST_EMPTY_SLOTS: assert property (!o_req[4] && !o_req[15] && !o_req[28]
      && o_req[26:23] == 4'h0 && o_req[36:33] == 4'h0 && o_req[47:43] == 5'h00)
    else $error("request on an empty bit position");
  AST_ANY_LEVEL: assert property (o_req_any == (o_req_level != 3'h0))
    else $error("any flag disagrees with level");
  AST_TOP_LEVEL: assert property (o_req[16] && $past(i_src_prio[16]) == 3'h7
      |-> o_req_level == 3'h7)
    else $error("highest priority not reported");

  // Main scenarios reached
  COV_ERR: cover property (o_pslverr);
  COV_TOP: cover property (o_req_level == 3'h7);
  COV_DROP: cover property (o_req_any ##1 !o_req_any);
endmodule // ifb_bank_asserts

// ### ifb_pkg.sv
package ifb_pkg;
  // One software-visible 16-bit register
  typedef logic [15:0] word16_t;
  // Three-bit source priority, 0 disables
  typedef logic [2:0] prio_t;
  // Priority of all 48 source slots, slot = 16 * register + bit
  typedef logic [47:0][2:0] prio_vec_t;
  // APB slave phase
  typedef enum logic [0:0] {PH_IDLE, PH_ACK} apb_phase_t;
endpackage

// ### ifb_regs.svh
`ifndef IFB_REGS_SVH
`define IFB_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses on the APB port)
// ****************************************************************
`define IFB_OFF_FLAGS_0 12'h000
`define IFB_OFF_FLAGS_1 12'h004
`define IFB_OFF_FLAGS_2 12'h008
`define IFB_OFF_ENABLES_0 12'h00C
`define IFB_OFF_PENDING_LO 12'h010
`define IFB_OFF_PENDING_HI 12'h014
`define IFB_OFF_LEVEL 12'h018

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define IFB_RST_WORD 16'h0000
`define IFB_RST_LEVEL 3'h0
`define IFB_PRIO_OFF 3'h0
`define IFB_ZERO_32 32'h0000_0000

// ****************************************************************
// Flag register 0 bit positions (enable register 0 mirrors them)
// ****************************************************************
`define IFB_B0_I2C_MASTER 4'hE
`define IFB_B0_I2C_SLAVE 4'hD
`define IFB_B0_NVM 4'hC
`define IFB_B0_ADC 4'hB
`define IFB_B0_UART_TX 4'hA
`define IFB_B0_UART_RX 4'h9
`define IFB_B0_SPI 4'h8
`define IFB_B0_TIMER3 4'h7
`define IFB_B0_TIMER2 4'h6
`define IFB_B0_CMP_OUT2 4'h5
`define IFB_B0_TIMER1 4'h3
`define IFB_B0_CMP_OUT1 4'h2
`define IFB_B0_CAPTURE1 4'h1
`define IFB_B0_EXT_PIN0 4'h0

// ****************************************************************
// Flag register 1 bit positions
// ****************************************************************
`define IFB_B1_COMP3 4'hF
`define IFB_B1_COMP2 4'hE
`define IFB_B1_COMP1 4'hD
`define IFB_B1_PIN_CHANGE 4'hB
`define IFB_B1_PULSE4 4'h6
`define IFB_B1_PULSE3 4'h5
`define IFB_B1_PULSE2 4'h4
`define IFB_B1_PULSE1 4'h3
`define IFB_B1_SPECIAL 4'h2
`define IFB_B1_EXT_PIN2 4'h1
`define IFB_B1_EXT_PIN1 4'h0

// ****************************************************************
// Flag register 2 bit positions
// ****************************************************************
`define IFB_B2_PAIR5 4'hA
`define IFB_B2_PAIR4 4'h9
`define IFB_B2_PAIR3 4'h8
`define IFB_B2_PAIR2 4'h7
`define IFB_B2_PAIR1 4'h6
`define IFB_B2_PAIR0 4'h5
`define IFB_B2_COMP4 4'h0

`endif

// ### ifb_src_model.sv
module ifb_src_model (
  input wire logic i_clk,
  output logic [15:0] o_evt_0,
  output logic [15:0] o_evt_1,
  output logic [15:0] o_evt_2
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Peripheral event sources
  // ****************************************************************
  // Sources idle low between events
  initial begin
    o_evt_0 = 16'h0000;
    o_evt_1 = 16'h0000;
    o_evt_2 = 16'h0000;
  end

  // Exactly one cycle high; a held level would re-set a cleared flag
  task automatic fire(input int r, input logic [15:0] m);
    @(posedge i_clk);
    if (r == 0) o_evt_0 <= m;
    else if (r == 1) o_evt_1 <= m;
    else o_evt_2 <= m;
    @(posedge i_clk);
    o_evt_0 <= 16'h0000;
    o_evt_1 <= 16'h0000;
    o_evt_2 <= 16'h0000;
  endtask
endmodule // ifb_src_model

// ### tb.sv
`include "ifb_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Stimulus, instances, bus tasks
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] evt0;
  logic [15:0] evt1;
  logic [15:0] evt2;
  logic [15:0] en1 = 16'h0000;
  logic [15:0] en2 = 16'h0000;
  ifb_pkg::prio_vec_t prio = '0;
  logic [47:0] req;
  logic [2:0] lvl;
  logic req_any;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  logic [11:0] offs [4] = '{`IFB_OFF_FLAGS_0, `IFB_OFF_FLAGS_1, `IFB_OFF_FLAGS_2,
    `IFB_OFF_ENABLES_0};
  logic [15:0] masks [4] = '{16'h7FEF, 16'hE87F, 16'h07E1, 16'h7FEF};

  // 25 MHz system clock
  always #20 clk = ~clk;

  ifb_bank u_dut (.i_mclk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_evt_flags_0(evt0), .i_evt_flags_1(evt1),
    .i_evt_flags_2(evt2), .i_en_ext_1(en1), .i_en_ext_2(en2), .i_src_prio(prio),
    .o_req(req), .o_req_level(lvl), .o_req_any(req_any));
  ifb_src_model u_src (.i_clk(clk), .o_evt_0(evt0), .o_evt_1(evt1), .o_evt_2(evt2));

  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Request held until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait count assumed; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic x);
    logic [31:0] q;
    logic err;
    apb(1'b0, a, 32'h0000_0000, q, err);
    chk($sformatf("read %h", a), 48'(e), 48'(q));
    chk($sformatf("read err %h", a), 48'(x), 48'(err));
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x);
    logic [31:0] q;
    logic err;
    apb(1'b1, a, d, q, err);
    chk($sformatf("write err %h", a), 48'(x), 48'(err));
  endtask

  // Let the edge land, then look at registered outputs
  task automatic settle();
    @(posedge clk);
    @(negedge clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Power-on values, then fill the bank and reset in mid-run
  task automatic t_reset();
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 7; i++) begin
        rd(12'(4 * i), 32'h0000_0000, 1'b0);
      end
      for (int r = 0; r < 4; r++) begin
        wr(offs[r], 32'hFFFF_FFFF, 1'b0);
      end
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
    end
    $display("test reset done");
  endtask

  // All ones then zeros: empty bits must stay zero
  task automatic t_rw();
    for (int r = 0; r < 4; r++) begin
      wr(offs[r], 32'hFFFF_FFFF, 1'b0);
      rd(offs[r], {16'h0000, masks[r]}, 1'b0);
      wr(offs[r], 32'h0000_0000, 1'b0);
      rd(offs[r], 32'h0000_0000, 1'b0);
    end
    $display("test read write done");
  endtask

  // Walk a single pulse over every bit of every flag register
  task automatic t_flags();
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 16; b++) begin
        u_src.fire(r, 16'h0001 << b);
        rd(offs[r], {16'h0000, masks[r] & (16'h0001 << b)}, 1'b0);
        wr(offs[r], 32'h0000_0000, 1'b0);
        rd(offs[r], 32'h0000_0000, 1'b0);
      end
    end
    // Pulse sampled at the clearing write edge: the set must win
    fork
      wr(`IFB_OFF_FLAGS_1, 32'h0000_0000, 1'b0);
      begin
        @(posedge clk);
        u_src.fire(1, 16'h0800);
      end
    join
    rd(`IFB_OFF_FLAGS_1, 32'h0000_0800, 1'b0);
    wr(`IFB_OFF_FLAGS_1, 32'h0000_0000, 1'b0);
    $display("test flags done");
  endtask

  // Three sources at priorities 1, 7, 5, then peeled away one by one
  task automatic t_req();
    @(posedge clk);
    prio[3] <= 3'h1;
    prio[16] <= 3'h7;
    prio[32] <= 3'h5;
    en1 <= 16'h0001;
    en2 <= 16'h0001;
    wr(`IFB_OFF_ENABLES_0, 32'h0000_0008, 1'b0);
    u_src.fire(0, 16'h0008);
    u_src.fire(1, 16'h0001);
    u_src.fire(2, 16'h0001);
    settle();
    chk("req", 48'h0001_0001_0008, req);
    chk("level", 48'h7, 48'(lvl));
    chk("any", 48'h1, 48'(req_any));
    rd(`IFB_OFF_PENDING_LO, 32'h0001_0008, 1'b0);
    rd(`IFB_OFF_PENDING_HI, 32'h0000_0001, 1'b0);
    rd(`IFB_OFF_LEVEL, 32'h0000_0007, 1'b0);
    // Status words are read-only: a write must leave them as they are
    wr(`IFB_OFF_PENDING_LO, 32'h0000_0000, 1'b0);
    rd(`IFB_OFF_PENDING_LO, 32'h0001_0008, 1'b0);
    @(posedge clk);
    en1 <= 16'h0000;
    settle();
    chk("req", 48'h0001_0000_0008, req);
    chk("level", 48'h5, 48'(lvl));
    @(posedge clk);
    prio[32] <= 3'h0;
    settle();
    chk("level", 48'h1, 48'(lvl));
    wr(`IFB_OFF_ENABLES_0, 32'h0000_0000, 1'b0);
    settle();
    chk("req", 48'h0, req);
    chk("any", 48'h0, 48'(req_any));
    for (int r = 0; r < 3; r++) begin
      wr(offs[r], 32'h0000_0000, 1'b0);
    end
    $display("test requests done");
  endtask

  // Unmapped places answer with an error, read-only places ignore writes
  task automatic t_err();
    rd(12'hFFC, 32'h0000_0000, 1'b1);
    wr(12'h01C, 32'hFFFF_FFFF, 1'b1);
    wr(`IFB_OFF_LEVEL, 32'hFFFF_FFFF, 1'b0);
    rd(`IFB_OFF_LEVEL, 32'h0000_0000, 1'b0);
    $display("test errors done");
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Run is well under a thousand cycles; far above that means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_flags();
    t_req();
    t_err();
    summarize();
  end
endmodule // tb

bind ifb_bank ifb_bank_asserts u_chk (.*);
